// [rtl/pde_pkg.sv]
package pde_pkg;
  localparam logic [11:0] PDE_OFS_PD_PIN  = 12'h000;
  localparam logic [11:0] PDE_OFS_PD_LAT  = 12'h004;
  localparam logic [11:0] PDE_OFS_PD_DIR  = 12'h008;
  localparam logic [11:0] PDE_OFS_PE_PIN  = 12'h00c;
  localparam logic [11:0] PDE_OFS_PE_LAT  = 12'h010;
  localparam logic [11:0] PDE_OFS_PE_DIR  = 12'h014;
  localparam logic [11:0] PDE_OFS_ANSEL   = 12'h018;
  localparam logic [11:0] PDE_OFS_PWMCFG  = 12'h01c;
  localparam logic [7:0]  PDE_RST_PD_DIR  = 8'hff;
  localparam logic [7:0]  PDE_RST_PD_LAT  = 8'h00;
  localparam logic [7:0]  PDE_RST_PE_DIR  = 8'h07;
  localparam logic [2:0]  PDE_RST_PE_LAT  = 3'h0;
  localparam logic [2:0]  PDE_RST_ANSEL   = 3'h7;
  localparam logic [5:0]  PDE_RST_PWMCFG  = 6'h00;
  localparam int          PDE_BIT_SLAVE_PORT_MODE_SELECT = 4;
  localparam int          PDE_BIT_IBOV    = 5;
  localparam int          PDE_BIT_OBF     = 6;
  localparam int          PDE_BIT_IBF     = 7;
  localparam int          PDE_PWM_LSB     = 5;
endpackage

// [rtl/pde_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module pde_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // data
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end
  assign sync_o = out_q;
endmodule
`default_nettype wire

// [rtl/pde_port.sv]
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [RULE1] slave port mode drives latch bits on port d pins, ignoring direction
// [RULE2] pins 5..7 carry pwm b,c,d when selected and direction is 0
// [RULE3] each pwm pin may tri-state during a shutdown event if configured
// [RULE4] slave port mode captures master write data from pins while chip select and write strobe are active
// [RULE5] port d direction bits are ignored while the slave port owns pins
// [RULE6] port d latch reads return latch value; writes update the latch
// [RULE7] large package: port e four bits, lower three with own direction
// [RULE8] port e pins selected analog read back as 0
// [RULE9] port e direction 1 disables driver, 0 drives latch onto pin
// [RULE10] analog selection never forces the port e driver off
// [RULE11] software keeps analog port e pins set as inputs
// [RULE12] power-on reset selects port e bits 2..0 as analog inputs
// [RULE13] upper four port e direction bits are slave port control and status
// [RULE14] port e latch reads and writes the latched value, not pins
// [RULE15] fourth port e pin is input only when reset pin config is 0
// [RULE16] with reset pin config set, that pin is the external reset input
// [RULE17] small package: port e only bit 3, and only without reset pin
// [RULE18] slave port mode bit 1 selects slave port, 0 general i/o
// [RULE19] port e data bits 7..4 read as 0
module pde_port
  import pde_pkg::*;
#(
  parameter bit LARGE_PKG = 1'b1
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [31:0] prdata,
  // configuration
  input  wire logic        ext_reset_pin_enable_cfg,
  // port d pins
  input  wire logic [7:0]  pd_pin_i,
  output logic      [7:0]  pd_pin_o,
  output logic      [7:0]  pd_pin_oe_n,
  // port e pins
  input  wire logic [3:0]  pe_pin_i,
  output logic      [2:0]  pe_pin_o,
  output logic      [2:0]  pe_pin_oe_n,
  output logic             ext_reset_req_n,
  // slave port strobes from the far bus, active low, synchronised
  input  wire logic        psp_rd_n,
  input  wire logic        psp_wr_n,
  input  wire logic        psp_cs_n,
  output logic      [7:0]  psp_rx_data,
  // enhanced pwm unit
  input  wire logic [2:0]  pwm_out,
  input  wire logic        pwm_shutdown
);
  logic [7:0] pd_lat_q;
  logic [7:0] pd_dir_q;
  logic [2:0] pe_lat_q;
  logic [2:0] pe_dir_q;
  logic [2:0] ansel_q;
  logic [5:0] pwmcfg_q;
  logic       psp_mode_q;
  logic       ibf_q;
  logic       obf_q;
  logic       ibov_q;
  logic [7:0] rx_q;
  logic [31:0] prdata_q;
  logic       strobe_prev_wr_q;
  logic       strobe_prev_rd_q;
  logic [7:0] pd_sync;
  logic [3:0] pe_sync;
  logic [2:0] strb_sync;
  logic       rst_pin_act;

  pde_sync #(.W(8)) u_sync_d (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i (pd_pin_i),
    .sync_o  (pd_sync)
  );
  pde_sync #(.W(4)) u_sync_e (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i (pe_pin_i),
    .sync_o  (pe_sync)
  );
  pde_sync #(.W(3)) u_sync_s (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i ({~psp_cs_n, ~psp_wr_n, ~psp_rd_n}),
    .sync_o  (strb_sync)
  );
  // reset pin kept active high so the sync reset value means idle
  pde_sync #(.W(1)) u_sync_r (
    .pclk    (pclk),
    .presetn (presetn),
    .async_i (~pe_pin_i[3]),
    .sync_o  (rst_pin_act)
  );

  // bus decode
  wire acc       = psel & penable;
  wire wr_acc    = acc & pwrite;
  wire rd_acc    = acc & ~pwrite;
  wire aligned   = (paddr[1:0] == 2'b00);
  wire hit_pdpin = aligned & (paddr == PDE_OFS_PD_PIN);
  wire hit_pdlat = aligned & (paddr == PDE_OFS_PD_LAT);
  wire hit_pddir = aligned & (paddr == PDE_OFS_PD_DIR);
  wire hit_pepin = aligned & (paddr == PDE_OFS_PE_PIN);
  wire hit_pelat = aligned & (paddr == PDE_OFS_PE_LAT);
  wire hit_pedir = aligned & (paddr == PDE_OFS_PE_DIR);
  wire hit_ansel = aligned & (paddr == PDE_OFS_ANSEL);
  wire hit_pwmc  = aligned & (paddr == PDE_OFS_PWMCFG);
  wire hit_any   = hit_pdpin | hit_pdlat | hit_pddir | hit_pepin |
                   hit_pelat | hit_pedir | hit_ansel | hit_pwmc;
  wire lat_wr_d  = wr_acc & (hit_pdpin | hit_pdlat);
  wire lat_wr_e  = wr_acc & (hit_pepin | hit_pelat);

  // slave port strobes
  wire cs_act  = strb_sync[2];
  wire wr_act  = cs_act & strb_sync[1];
  wire rd_act  = cs_act & strb_sync[0];
  wire wr_end  = strobe_prev_wr_q & ~wr_act;
  wire rd_end  = strobe_prev_rd_q & ~rd_act;
  wire pe_here = LARGE_PKG;
  wire psp_en  = psp_mode_q & pe_here;                       // [RULE18]
  wire sw_rd_rx = rd_acc & (hit_pdpin | hit_pdlat) & psp_en;

  // pin drive: pwm over slave port over plain port
  wire [7:0] pwm_sel;
  wire [7:0] pwm_val;
  wire [7:0] pwm_tri;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pd
      if (g >= PDE_PWM_LSB) begin : g_pwm
        assign pwm_sel[g] = pwmcfg_q[g-PDE_PWM_LSB] & ~pd_dir_q[g];  // [RULE2]
        assign pwm_val[g] = pwm_out[g-PDE_PWM_LSB];                  // [RULE2]
        assign pwm_tri[g] = pwmcfg_q[g-PDE_PWM_LSB+3] & pwm_shutdown; // [RULE3]
      end else begin : g_nopwm
        assign pwm_sel[g] = 1'b0;
        assign pwm_val[g] = 1'b0;
        assign pwm_tri[g] = 1'b0;
      end
      assign pd_pin_o[g] = pwm_sel[g] ? pwm_val[g] : pd_lat_q[g];  // [RULE1]
      assign pd_pin_oe_n[g] = pwm_sel[g] ? pwm_tri[g] :
                              psp_en ? ~rd_act :                  // [RULE5]
                              pd_dir_q[g];
    end
  endgenerate

  // port e drive
  assign pe_pin_o    = pe_here ? pe_lat_q : 3'h0;
  assign pe_pin_oe_n = pe_here ? pe_dir_q : 3'h7;                 // [RULE9] [RULE10]
  assign ext_reset_req_n = ext_reset_pin_enable_cfg ? ~rst_pin_act :
                           1'b1;                                  // [RULE16]

  // read views
  wire       re3_bit   = ~ext_reset_pin_enable_cfg & pe_sync[3];  // [RULE15] [RULE17]
  wire [2:0] pe_low_rd = pe_here ? (pe_sync[2:0] & ~ansel_q) : 3'h0; // [RULE8] [RULE7]
  wire [7:0] pe_pin_rd = {4'h0, re3_bit, pe_low_rd};              // [RULE19]
  wire [7:0] pd_pin_rd = psp_en ? rx_q : pd_sync;
  wire [7:0] pe_dir_rd = pe_here ? {ibf_q, obf_q, ibov_q, psp_mode_q, 1'b0,
                         pe_dir_q} : 8'h00;                        // [RULE13]
  wire [31:0] rd_mux =
    hit_pdpin ? {24'h0, pd_pin_rd} :
    hit_pdlat ? {24'h0, pd_lat_q} :                               // [RULE6]
    hit_pddir ? {24'h0, pd_dir_q} :
    hit_pepin ? {24'h0, pe_pin_rd} :
    hit_pelat ? {29'h0, pe_lat_q} :                               // [RULE14]
    hit_pedir ? {24'h0, pe_dir_rd} :
    hit_ansel ? {29'h0, ansel_q} :
    hit_pwmc  ? {26'h0, pwmcfg_q} : 32'h0;

  assign pready  = 1'b1;
  assign pslverr = acc & ~hit_any;
  assign prdata  = prdata_q;
  assign psp_rx_data = rx_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_lat_q <= PDE_RST_PD_LAT;
      pd_dir_q <= PDE_RST_PD_DIR;
      pe_lat_q <= PDE_RST_PE_LAT;
      pe_dir_q <= PDE_RST_PE_DIR[2:0];
      psp_mode_q <= 1'b0;
      ansel_q  <= PDE_RST_ANSEL;                                  // [RULE12]
      pwmcfg_q <= PDE_RST_PWMCFG;
    end else begin
      if (lat_wr_d) begin
        pd_lat_q <= pwdata[7:0];                                  // [RULE6]
      end
      if (wr_acc & hit_pddir) begin
        pd_dir_q <= pwdata[7:0];
      end
      if (lat_wr_e) begin
        pe_lat_q <= pwdata[2:0];                                  // [RULE14]
      end
      if (wr_acc & hit_pedir) begin
        pe_dir_q   <= pwdata[2:0];                                // [RULE7]
        psp_mode_q <= pwdata[PDE_BIT_SLAVE_PORT_MODE_SELECT];                    // [RULE13]
      end
      if (wr_acc & hit_ansel) begin
        ansel_q <= pwdata[2:0];
      end
      if (wr_acc & hit_pwmc) begin
        pwmcfg_q <= pwdata[5:0];
      end
    end
  end

  // slave port buffers and flags; set wins over clear
  wire ibov_clr = wr_acc & hit_pedir & ~pwdata[PDE_BIT_IBOV];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_prev_wr_q <= 1'b0;
      strobe_prev_rd_q <= 1'b0;
      rx_q   <= 8'h00;
      ibf_q  <= 1'b0;
      obf_q  <= 1'b0;
      ibov_q <= 1'b0;
    end else begin
      strobe_prev_wr_q <= wr_act & psp_en;
      strobe_prev_rd_q <= rd_act & psp_en;
      if (psp_en & wr_act) begin
        rx_q <= pd_sync;                                          // [RULE4]
      end
      if (wr_end) begin
        ibf_q <= 1'b1;
      end else if (sw_rd_rx) begin
        ibf_q <= 1'b0;
      end
      if (wr_end & ibf_q) begin
        ibov_q <= 1'b1;
      end else if (ibov_clr) begin
        ibov_q <= 1'b0;
      end
      if (lat_wr_d & psp_en) begin
        obf_q <= 1'b1;
      end else if (rd_end) begin
        obf_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/pde_port_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module pde_mon
  import pde_pkg::*;
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // pins
  input wire logic        ext_reset_pin_enable_cfg,
  input wire logic [3:0]  pe_pin_i,
  input wire logic [7:0]  pd_pin_o,
  input wire logic [7:0]  pd_pin_oe_n,
  input wire logic [2:0]  pe_pin_o,
  input wire logic [2:0]  pe_pin_oe_n,
  input wire logic        ext_reset_req_n
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire wr = psel & penable & pwrite;
  AST_PE_DIR: assert property (
    wr && paddr == PDE_OFS_PE_DIR |=> pe_pin_oe_n == $past(pwdata[2:0]))
    else $error("pe dir");
  AST_ANSEL: assert property (
    wr && paddr == PDE_OFS_ANSEL |=> $stable(pe_pin_oe_n))
    else $error("ansel moved driver");
  AST_PE_LAT: assert property (
    wr && paddr == PDE_OFS_PE_LAT |=> pe_pin_o == $past(pwdata[2:0]))
    else $error("pe latch");
  AST_PD_LAT: assert property (
    wr && paddr == PDE_OFS_PD_LAT |=> pd_pin_o[4:0] == $past(pwdata[4:0]))
    else $error("pd latch");
  AST_E3_PORT: assert property (
    !ext_reset_pin_enable_cfg |-> ext_reset_req_n)
    else $error("reset while port bit");
  AST_E3_RST: assert property (
    (ext_reset_pin_enable_cfg && !pe_pin_i[3]) [*6] |-> !ext_reset_req_n)
    else $error("reset pin lost");
  AST_RST_IN: assert property (
    $rose(presetn) |-> pd_pin_oe_n == 8'hff && pe_pin_oe_n == 3'h7)
    else $error("pins not inputs");
  AST_NO_WAIT: assert property (
    psel && penable |-> pready)
    else $error("wait state");
  cover property (wr && paddr == PDE_OFS_PE_DIR);
  cover property (!ext_reset_req_n);
  cover property (psel && penable && !pwrite);
endmodule
bind pde_port pde_mon u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .ext_reset_pin_enable_cfg, .pe_pin_i,
  .pd_pin_o, .pd_pin_oe_n, .pe_pin_o, .pe_pin_oe_n, .ext_reset_req_n);
`default_nettype wire

// [sim/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pde_pkg::*;
  typedef struct packed {
    logic       w;
    logic [7:0] a;
    logic [7:0] d;
  } pde_row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        cfg = 0, rd_n = 1, wr_n = 1, cs_n = 1, shut = 0;
  logic        pready, pslverr, lerr, ext_reset_req_n;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [7:0]  pd_i = 0, pd_o, pd_oe_n, rx;
  logic [3:0]  pe_i = 4'hf;
  logic [2:0]  pe_o, pe_oe_n, pwm = 3'h5;
  int          n_fail = 0, n_checks = 0;
  pde_row_t    rows[$] = '{
    '{1'b1, 8'h14, 8'hff}, '{1'b0, 8'h14, 8'h17}, '{1'b1, 8'h14, 8'h00},
    '{1'b0, 8'h14, 8'h00}, '{1'b1, 8'h04, 8'ha5}, '{1'b0, 8'h04, 8'ha5},
    '{1'b1, 8'h00, 8'h3c}, '{1'b0, 8'h04, 8'h3c}, '{1'b1, 8'h10, 8'h05},
    '{1'b0, 8'h10, 8'h05}, '{1'b1, 8'h18, 8'h00}, '{1'b0, 8'h0c, 8'h0f},
    '{1'b1, 8'h18, 8'h07}, '{1'b0, 8'h0c, 8'h08}, '{1'b0, 8'h20, 8'h00}};
  pde_row_t    rst[$] = '{
    '{1'b0, 8'h08, 8'hff}, '{1'b0, 8'h14, 8'h07}, '{1'b0, 8'h18, 8'h07},
    '{1'b0, 8'h04, 8'h00}, '{1'b0, 8'h0c, 8'h08}};
  pde_port uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .prdata, .ext_reset_pin_enable_cfg(cfg),
    .pd_pin_i(pd_i), .pd_pin_o(pd_o), .pd_pin_oe_n(pd_oe_n),
    .pe_pin_i(pe_i), .pe_pin_o(pe_o), .pe_pin_oe_n(pe_oe_n),
    .ext_reset_req_n, .psp_rd_n(rd_n), .psp_wr_n(wr_n), .psp_cs_n(cs_n),
    .psp_rx_data(rx), .pwm_out(pwm), .pwm_shutdown(shut));
  always #50 pclk = ~pclk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    if (n_fail == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    logic ok;
    ok = 0;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {4'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge pclk);
      ok = (pready === 1'b1);
    end
    r = prdata;
    lerr = pslverr;
    psel <= 0;
    penable <= 0;
    if (!ok) begin
      n_fail++;
      close_out;
    end
  endtask
  task automatic run(input pde_row_t q[$]);
    foreach (q[i]) begin
      xfer(q[i].w, q[i].a, {24'h0, q[i].d});
      if (!q[i].w)
        chk(r, {24'h0, q[i].d});
    end
  endtask
  initial begin
    tick(2);
    presetn <= 1;
    tick(6);
    run(rows);
    chk(32'(lerr), 32'h1);
    chk(32'(pe_oe_n), 32'h0);
    chk(32'(pe_o), 32'h5);
    xfer(1, 8'h08, 0);
    xfer(1, 8'h1c, 32'h3f);
    tick(1);
    chk(32'(pd_o[7:5]), 32'h5);
    chk(32'(pd_oe_n), 32'h0);
    shut <= 1;
    tick(2);
    chk(32'(pd_oe_n), 32'he0);
    shut <= 0;
    xfer(1, 8'h1c, 0);
    xfer(1, 8'h14, 32'h10);
    tick(1);
    chk(32'(pd_oe_n), 32'hff);
    cs_n <= 0;
    rd_n <= 0;
    tick(5);
    chk(32'(pd_oe_n), 32'h0);
    chk(32'(pd_o), 32'h3c);
    rd_n <= 1;
    pd_i <= 8'h96;
    tick(5);
    wr_n <= 0;
    tick(5);
    cs_n <= 1;
    wr_n <= 1;
    tick(5);
    chk(32'(rx), 32'h96);
    xfer(0, 8'h14, 0);
    chk(r, 32'h90);
    xfer(0, 8'h00, 0);
    chk(r, 32'h96);
    xfer(0, 8'h14, 0);
    chk(r, 32'h10);
    cfg <= 1;
    pe_i <= 4'h7;
    tick(7);
    chk(32'(ext_reset_req_n), 32'h0);
    cfg <= 0;
    pe_i <= 4'hf;
    tick(1);
    chk(32'(ext_reset_req_n), 32'h1);
    presetn <= 0;
    tick(2);
    presetn <= 1;
    tick(6);
    run(rst);
    close_out;
  end
endmodule
`default_nettype wire
